// ---- src/mbx_pkg.sv ----
package mbx_pkg;

	localparam int ADDR_W = 12;
	localparam int MAILBOX_COUNT = 4;
	localparam int SEM_COUNT = 8;
	localparam int LOCAL_LINES = 8;
	localparam int BACKPLANE_LINES = 7;

	localparam logic [11:0] LOCAL_MAP_OFFSET = 12'h0340;
	localparam logic [11:0] BACKPLANE_MAP_OFFSET = 12'h0344;
	localparam logic [11:0] MAILBOX_0_OFFSET = 12'h0348;
	localparam logic [11:0] MAILBOX_1_OFFSET = 12'h034C;
	localparam logic [11:0] MAILBOX_2_OFFSET = 12'h0350;
	localparam logic [11:0] MAILBOX_3_OFFSET = 12'h0354;
	localparam logic [11:0] SEM_LOW_OFFSET = 12'h0358;
	localparam logic [11:0] SEM_HIGH_OFFSET = 12'h035C;
	localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h0370;
	localparam logic [11:0] IRQ_MASK_OFFSET = 12'h0374;

	localparam int SEM_FLAG_POS = 7;
	localparam int TAG_W = 7;
	localparam int ROUTE_CODE_W = 3;
	localparam int ROUTE_FIELD_STRIDE = 4;
	localparam logic [31:0] ROUTE_MAP_WRITABLE = 32'h7777_7777;

	localparam logic [31:0] MAILBOX_RESET = 32'h0000_0000;
	localparam logic [31:0] ROUTE_MAP_RESET = 32'h0000_0000;
	localparam logic [7:0] SEM_LANE_RESET = 8'h00;
	localparam logic [3:0] IRQ_STATUS_RESET = 4'h0;
	localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
	localparam logic [7:0] LOCAL_IDLE_N = 8'hFF;
	localparam logic [6:0] BACKPLANE_IDLE_N = 7'h7F;

endpackage

// ---- src/sem_lane_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface sem_lane_if;
	logic wr;
	logic [7:0] wdata;
	logic [7:0] value;
	modport lane (input wr, input wdata, output value);
	modport owner (output wr, output wdata, input value);
endinterface // sem_lane_if
`default_nettype wire

// ---- src/semaphore_lane.sv ----
`timescale 1ns/10ps
`default_nettype none
module semaphore_lane (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	sem_lane_if.lane bus
);
	typedef struct packed {
		logic semaphore_flag;
		logic [mbx_pkg::TAG_W-1:0] semaphore_owner_tag;
	} lane_type;

	lane_type st;
	lane_type next_st;

	always_comb begin
		next_st = st;
		if (ce_i && bus.wr) begin
			// An owner tag can only change while the semaphore is free, so a claim and its tag land together.
			if (!st.semaphore_flag) begin
				next_st.semaphore_owner_tag = bus.wdata[mbx_pkg::TAG_W-1:0];
			end
			next_st.semaphore_flag = bus.wdata[mbx_pkg::SEM_FLAG_POS];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			st <= lane_type'(mbx_pkg::SEM_LANE_RESET);
		end else begin
			st <= next_st;
		end
	end

	assign bus.value = st;
endmodule // semaphore_lane
`default_nettype wire

// ---- src/irq_router.sv ----
`timescale 1ns/10ps
`default_nettype none
module irq_router #(
	parameter int SOURCES = mbx_pkg::MAILBOX_COUNT
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [SOURCES-1:0] pending_i,
	input wire logic [31:0] local_map_i,
	input wire logic [31:0] backplane_map_i,
	output logic [7:0] local_interrupt_out_n_o,
	output logic [6:0] backplane_irq_n_o
);
	typedef struct packed {
		logic [7:0] local_n;
		logic [6:0] back_n;
	} route_type;

	route_type st;
	route_type next_st;

	if (SOURCES < 1 || SOURCES * mbx_pkg::ROUTE_FIELD_STRIDE > 32) begin : g_bad_sources
		$error("irq_router: SOURCES does not fit one route map word");
	end

	function automatic logic [2:0] route_code(input logic [31:0] map, input int src);
		route_code = map[src*mbx_pkg::ROUTE_FIELD_STRIDE +: mbx_pkg::ROUTE_CODE_W];
	endfunction

	always_comb begin
		next_st = st;
		if (ce_i) begin
			next_st.local_n = mbx_pkg::LOCAL_IDLE_N;
			next_st.back_n = mbx_pkg::BACKPLANE_IDLE_N;
			for (int s = 0; s < SOURCES; s++) begin
				if (pending_i[s]) begin
					next_st.local_n[route_code(local_map_i, s)] = 1'b0;
					// Code zero has no backplane line, so it quietly masks the source there.
					if (route_code(backplane_map_i, s) != 3'h0) begin
						next_st.back_n[route_code(backplane_map_i, s) - 3'h1] = 1'b0;
					end
				end
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			st <= {mbx_pkg::LOCAL_IDLE_N, mbx_pkg::BACKPLANE_IDLE_N};
		end else begin
			st <= next_st;
		end
	end

	assign local_interrupt_out_n_o = st.local_n;
	assign backplane_irq_n_o = st.back_n;
endmodule // irq_router
`default_nettype wire

// ---- src/mailbox_semaphore_regs.sv ----
// The plain strobed port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module mailbox_semaphore_regs (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [11:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] byte_en_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic irq_o,
	output logic [7:0] local_interrupt_out_n_o,
	output logic [6:0] backplane_irq_n_o
);
	localparam int MB = mbx_pkg::MAILBOX_COUNT;
	localparam logic [MB-1:0][11:0] MAILBOX_OFFSET = {mbx_pkg::MAILBOX_3_OFFSET,
		mbx_pkg::MAILBOX_2_OFFSET, mbx_pkg::MAILBOX_1_OFFSET, mbx_pkg::MAILBOX_0_OFFSET};

	typedef struct packed {
		logic [MB-1:0][31:0] mailbox;
		logic [31:0] local_irq_route_map;
		logic [31:0] backplane_irq_route_map;
		logic [MB-1:0] status;
		logic [MB-1:0] mask;
		logic [31:0] rdata;
		logic irq;
	} regs_type;

	regs_type st;
	regs_type next_st;
	logic [mbx_pkg::SEM_COUNT-1:0][7:0] sem_val;

	// Byte enables let mailbox and route map words be written one byte at a time.
	function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] val,
		input logic [3:0] be);
		merge_bytes = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				merge_bytes[8*b +: 8] = val[8*b +: 8];
			end
		end
	endfunction

	sem_lane_if lane_bus[mbx_pkg::SEM_COUNT] ();

	for (genvar g = 0; g < mbx_pkg::SEM_COUNT; g++) begin : g_lane
		localparam logic [11:0] WORD = (g < 4) ? mbx_pkg::SEM_LOW_OFFSET : mbx_pkg::SEM_HIGH_OFFSET;
		// A wider access simply writes every enabled lane; each lane still guards its own tag.
		assign lane_bus[g].wr = ce_i && wr_i && addr_i == WORD && byte_en_i[g % 4];
		assign lane_bus[g].wdata = wdata_i[8*(g%4) +: 8];
		assign sem_val[g] = lane_bus[g].value;
		semaphore_lane u_lane (
			.core_clk_i(core_clk_i),
			.rst_i(rst_i),
			.ce_i(ce_i),
			.bus(lane_bus[g])
		);
	end

	always_comb begin
		logic [MB-1:0] set_ev;
		logic [MB-1:0] clr;
		logic [31:0] rval;
		set_ev = '0;
		clr = '0;
		rval = 32'h0000_0000;
		next_st = st;
		if (ce_i) begin
			if (wr_i) begin
				for (int m = 0; m < MB; m++) begin
					if (addr_i == MAILBOX_OFFSET[m]) begin
						next_st.mailbox[m] = merge_bytes(st.mailbox[m], wdata_i, byte_en_i);
						set_ev[m] = |byte_en_i;
					end
				end
				if (addr_i == mbx_pkg::LOCAL_MAP_OFFSET) begin
					next_st.local_irq_route_map = merge_bytes(st.local_irq_route_map, wdata_i,
						byte_en_i) & mbx_pkg::ROUTE_MAP_WRITABLE;
				end
				if (addr_i == mbx_pkg::BACKPLANE_MAP_OFFSET) begin
					next_st.backplane_irq_route_map = merge_bytes(st.backplane_irq_route_map, wdata_i,
						byte_en_i) & mbx_pkg::ROUTE_MAP_WRITABLE;
				end
				if (addr_i == mbx_pkg::IRQ_STATUS_OFFSET && byte_en_i[0]) begin
					clr = wdata_i[MB-1:0];
				end
				if (addr_i == mbx_pkg::IRQ_MASK_OFFSET && byte_en_i[0]) begin
					next_st.mask = wdata_i[MB-1:0];
				end
			end
			// A mailbox write in the same cycle as its clear keeps the bit set.
			next_st.status = (st.status & ~clr) | set_ev;
			next_st.irq = |(next_st.status & next_st.mask);
			if (rd_i) begin
				for (int m = 0; m < MB; m++) begin
					if (addr_i == MAILBOX_OFFSET[m]) begin
						rval = st.mailbox[m];
					end
				end
				unique case (addr_i)
					mbx_pkg::LOCAL_MAP_OFFSET: rval = st.local_irq_route_map;
					mbx_pkg::BACKPLANE_MAP_OFFSET: rval = st.backplane_irq_route_map;
					mbx_pkg::SEM_LOW_OFFSET: rval = sem_val[3:0];
					mbx_pkg::SEM_HIGH_OFFSET: rval = sem_val[7:4];
					mbx_pkg::IRQ_STATUS_OFFSET: rval[MB-1:0] = st.status;
					mbx_pkg::IRQ_MASK_OFFSET: rval[MB-1:0] = st.mask;
					default: ;
				endcase
			end
			next_st.rdata = rval;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			st.mailbox <= {MB{mbx_pkg::MAILBOX_RESET}};
			st.local_irq_route_map <= mbx_pkg::ROUTE_MAP_RESET;
			st.backplane_irq_route_map <= mbx_pkg::ROUTE_MAP_RESET;
			st.status <= mbx_pkg::IRQ_STATUS_RESET;
			st.mask <= mbx_pkg::IRQ_MASK_RESET;
			st.rdata <= 32'h0000_0000;
			st.irq <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	irq_router #(
		.SOURCES(MB)
	) u_router (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.pending_i(st.status & st.mask),
		.local_map_i(st.local_irq_route_map),
		.backplane_map_i(st.backplane_irq_route_map),
		.local_interrupt_out_n_o(local_interrupt_out_n_o),
		.backplane_irq_n_o(backplane_irq_n_o)
	);

	assign rdata_o = st.rdata;
	assign irq_o = st.irq;

	// Checks below watch what this block drives; reset masks them except the reset check itself.
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	a_mailbox_reset_zero: assert property (disable iff (1'b0)
		rst_i |=> st.mailbox == '0 && rdata_o == 32'h0000_0000)
		else $error("mailbox not cleared by reset");

	a_mailbox_full_write: assert property (ce_i && wr_i && byte_en_i == 4'hF &&
		addr_i == mbx_pkg::MAILBOX_1_OFFSET |=> st.mailbox[1] == $past(wdata_i))
		else $error("full mailbox write did not land");

	a_mailbox_read_back: assert property (ce_i && rd_i && addr_i == mbx_pkg::MAILBOX_2_OFFSET
		|=> rdata_o == $past(st.mailbox[2]))
		else $error("mailbox read returned wrong word");

	a_sem_low_layout: assert property (ce_i && rd_i && addr_i == mbx_pkg::SEM_LOW_OFFSET
		|=> rdata_o[7:0] == $past(sem_val[0]) && rdata_o[31:24] == $past(sem_val[3]))
		else $error("low semaphore word layout wrong");

	a_sem_high_layout: assert property (ce_i && rd_i && addr_i == mbx_pkg::SEM_HIGH_OFFSET
		|=> rdata_o[7:0] == $past(sem_val[4]) && rdata_o[31:24] == $past(sem_val[7]))
		else $error("high semaphore word layout wrong");

	a_free_tag_write: assert property (ce_i && wr_i && addr_i == mbx_pkg::SEM_LOW_OFFSET &&
		byte_en_i[0] && !sem_val[0][7] |=> sem_val[0] == $past(wdata_i[7:0]))
		else $error("free semaphore did not take flag and tag");

	a_held_tag_stays: assert property (sem_val[5][7] && ce_i && wr_i && byte_en_i[1] &&
		addr_i == mbx_pkg::SEM_HIGH_OFFSET |=> sem_val[5][6:0] == $past(sem_val[5][6:0])
		&& sem_val[5][7] == $past(wdata_i[15]))
		else $error("held semaphore tag changed");

	a_claim_then_confirm: assert property (ce_i && wr_i && addr_i == mbx_pkg::SEM_LOW_OFFSET &&
		byte_en_i == 4'h4 && !sem_val[2][7] && wdata_i[23] ##1 ce_i && rd_i &&
		addr_i == mbx_pkg::SEM_LOW_OFFSET |=> rdata_o[23:16] == $past(wdata_i[23:16], 2))
		else $error("claimed tag not read back");

	a_local_route: assert property (ce_i && (st.status & st.mask) == 4'h1 &&
		st.local_irq_route_map[2:0] == 3'h5 |=> local_interrupt_out_n_o == 8'hDF)
		else $error("mailbox interrupt on wrong local output");

	a_backplane_route: assert property (ce_i && (st.status & st.mask) == 4'h8 &&
		st.backplane_irq_route_map[14:12] == 3'h3 |=> backplane_irq_n_o == 7'h7B)
		else $error("mailbox interrupt on wrong backplane line");

	a_backplane_masked: assert property (ce_i && st.backplane_irq_route_map == 32'h0000_0000
		|=> backplane_irq_n_o == 7'h7F)
		else $error("code zero did not mask backplane line");

	a_status_set_wins: assert property (ce_i && wr_i && byte_en_i == 4'hF &&
		addr_i == mbx_pkg::MAILBOX_0_OFFSET |=> st.status[0] ##1 (st.status[0] || $past(ce_i && wr_i)))
		else $error("mailbox event lost");

	a_irq_level: assert property (irq_o == |(st.status & st.mask))
		else $error("interrupt output disagrees with status");

	c_claim_semaphore: cover property (ce_i && wr_i && addr_i == mbx_pkg::SEM_LOW_OFFSET &&
		byte_en_i[0] && wdata_i[7] && !sem_val[0][7]);
	c_refused_claim: cover property (ce_i && wr_i && addr_i == mbx_pkg::SEM_HIGH_OFFSET &&
		byte_en_i[0] && sem_val[4][7] && wdata_i[6:0] != sem_val[4][6:0]);
	c_irq_raised: cover property (!irq_o ##1 irq_o);
	c_backplane_drive: cover property (backplane_irq_n_o != 7'h7F);
endmodule // mailbox_semaphore_regs
`default_nettype wire

// ---- testbench/sw_master.sv ----
`timescale 1ns/10ps
`default_nettype none
module sw_master (
	input wire logic core_clk_i,
	input wire logic [31:0] rdata_i,
	output logic [11:0] addr_o,
	output logic [31:0] wdata_o,
	output logic [3:0] byte_en_o,
	output logic wr_o,
	output logic rd_o
);
	initial begin
		addr_o = 12'h0000;
		wdata_o = 32'h0000_0000;
		byte_en_o = 4'h0;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// Released address and data lines flip to their inverse so a stale value is never mistaken for live data.
	task automatic write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge core_clk_i);
		addr_o <= a;
		wdata_o <= d;
		byte_en_o <= be;
		wr_o <= 1'b1;
		@(posedge core_clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask
	task automatic read(input logic [11:0] a, output logic [31:0] d);
		@(posedge core_clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge core_clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		@(negedge core_clk_i);
		d = rdata_i;
	endtask
	task automatic write_lane(input logic [11:0] a, input int lane, input logic [7:0] b);
		write(a, {4{b}}, 4'(4'b0001 << lane));
	endtask
endmodule // sw_master
`default_nettype wire

// ---- testbench/test_mailbox_semaphore_regs.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_mailbox_semaphore_regs;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic [11:0] addr;
	logic [31:0] wdata;
	logic [3:0] be;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	logic irq;
	logic [7:0] local_interrupt_out_n;
	logic [6:0] bp_n;
	int checked = 0;
	int bad_count = 0;
	logic [7:0] m [8];
	always #5 core_clk_i = ~core_clk_i;
	sw_master SW (.core_clk_i(core_clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
		.byte_en_o(be), .wr_o(wr), .rd_o(rd));
	mailbox_semaphore_regs DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.addr_i(addr), .wdata_i(wdata), .byte_en_i(be), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.irq_o(irq), .local_interrupt_out_n_o(local_interrupt_out_n), .backplane_irq_n_o(bp_n));
	task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic expect_reg(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] d;
		SW.read(a, d);
		check($sformatf("reg %h", a), e, d);
	endtask
	task automatic expect_pins(input logic i, input logic [7:0] l, input logic [6:0] b);
		repeat (2) @(negedge core_clk_i);
		check("irq", {31'h0, i}, {31'h0, irq});
		check("local pins", {24'h0, l}, {24'h0, local_interrupt_out_n});
		check("backplane pins", {25'h0, b}, {25'h0, bp_n});
	endtask
	task automatic test_reset;
		expect_pins(1'b0, 8'hFF, 7'h7F);
		for (int i = 0; i < 6; i++) begin
			expect_reg(mbx_pkg::MAILBOX_0_OFFSET + 12'(4 * i), 32'h0000_0000);
		end
		$display("test_reset done");
	endtask
	task automatic test_mailbox;
		for (int i = 0; i < 4; i++) begin
			SW.write(mbx_pkg::MAILBOX_0_OFFSET + 12'(4 * i), 32'hA5C3_0F00 | i, 4'hF);
		end
		SW.write(12'h0360, 32'hFFFF_FFFF, 4'hF);
		SW.write(mbx_pkg::MAILBOX_1_OFFSET, 32'h1234_5678, 4'b0100);
		for (int i = 0; i < 4; i++) begin
			expect_reg(mbx_pkg::MAILBOX_0_OFFSET + 12'(4 * i),
				(i == 1) ? 32'hA534_0F01 : (32'hA5C3_0F00 | i));
		end
		expect_reg(12'h0360, 32'h0000_0000);
		$display("test_mailbox done");
	endtask
	task automatic sem_words;
		expect_reg(mbx_pkg::SEM_LOW_OFFSET, {m[3], m[2], m[1], m[0]});
		expect_reg(mbx_pkg::SEM_HIGH_OFFSET, {m[7], m[6], m[5], m[4]});
	endtask
	task automatic test_semaphore;
		logic [11:0] a;
		logic [6:0] t;
		for (int i = 0; i < 8; i++) begin
			m[i] = 8'h00;
		end
		for (int i = 0; i < 8; i++) begin
			a = (i < 4) ? mbx_pkg::SEM_LOW_OFFSET : mbx_pkg::SEM_HIGH_OFFSET;
			t = 7'(i + 1);
			SW.write_lane(a, i % 4, {1'b1, t});
			m[i] = {1'b1, t};
			sem_words();
			SW.write_lane(a, i % 4, {1'b1, ~t});
			sem_words();
			SW.write_lane(a, i % 4, 8'h00);
			m[i] = {1'b0, t};
			sem_words();
			SW.write_lane(a, i % 4, {1'b0, ~t});
			m[i] = {1'b0, ~t};
			sem_words();
		end
		$display("test_semaphore done");
	endtask
	task automatic test_irq;
		int mb;
		SW.write(mbx_pkg::IRQ_STATUS_OFFSET, 32'h0000_000F, 4'h1);
		// The eight codes rotate over the four mailboxes so all four map fields get exercised.
		for (int c = 0; c < 8; c++) begin
			mb = c % 4;
			SW.write(mbx_pkg::LOCAL_MAP_OFFSET, 32'(c) << (4 * mb), 4'hF);
			SW.write(mbx_pkg::BACKPLANE_MAP_OFFSET, 32'(c) << (4 * mb), 4'hF);
			SW.write(mbx_pkg::IRQ_MASK_OFFSET, 32'h0000_0001 << mb, 4'h1);
			SW.write(mbx_pkg::MAILBOX_0_OFFSET + 12'(4 * mb), 32'h0000_0000, 4'h1);
			expect_pins(1'b1, ~(8'h01 << c), (c == 0) ? 7'h7F : ~(7'h01 << (c - 1)));
			SW.write(mbx_pkg::IRQ_STATUS_OFFSET, 32'h0000_0001 << mb, 4'h1);
			expect_pins(1'b0, 8'hFF, 7'h7F);
		end
		SW.write(mbx_pkg::IRQ_MASK_OFFSET, 32'h0000_0000, 4'h1);
		SW.write(mbx_pkg::MAILBOX_2_OFFSET, 32'h0000_0000, 4'h1);
		expect_pins(1'b0, 8'hFF, 7'h7F);
		expect_reg(mbx_pkg::IRQ_STATUS_OFFSET, 32'h0000_0004);
		$display("test_irq done");
	endtask
	// Writes under a low clock enable must vanish, and a second reset must clear mailbox 3, the status and the pins.
	task automatic test_freeze_reset;
		SW.write(mbx_pkg::MAILBOX_3_OFFSET, 32'h0000_C0DE, 4'hF);
		@(posedge core_clk_i);
		ce_i <= 1'b0;
		SW.write(mbx_pkg::MAILBOX_3_OFFSET, 32'hFFFF_FFFF, 4'hF);
		@(posedge core_clk_i);
		ce_i <= 1'b1;
		expect_reg(mbx_pkg::MAILBOX_3_OFFSET, 32'h0000_C0DE);
		@(negedge core_clk_i);
		check("rdata idle", 32'h0000_0000, rdata);
		@(posedge core_clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		rst_i <= 1'b0;
		expect_reg(mbx_pkg::MAILBOX_3_OFFSET, 32'h0000_0000);
		expect_reg(mbx_pkg::IRQ_STATUS_OFFSET, 32'h0000_0000);
		expect_pins(1'b0, 8'hFF, 7'h7F);
		$display("test_freeze_reset done");
	endtask
	task automatic tally_and_finish;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		#200000;
		bad_count++;
		tally_and_finish();
	end
	initial begin
		repeat (4) @(posedge core_clk_i);
		rst_i <= 1'b0;
		test_reset();
		test_mailbox();
		test_semaphore();
		test_irq();
		test_freeze_reset();
		tally_and_finish();
	end
endmodule // test_mailbox_semaphore_regs
`default_nettype wire
